// [port_one_gpio_pin_mux.sv]
// Port one: output latch, pin-state readback and timer pin sharing for pins 7 to 5
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "port_one_regs.svh"

module port_one_gpio_pin_mux
    import port_one_pkg::*;
(
    // Clock, reset and enable
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,

    // Register port
    input  wire logic [1:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,

    // Package pins
    input  wire logic [7:0] pin_i,
    output logic      [7:0] pin_o,
    output logic      [7:0] pin_oe_o,

    // Timer configuration and compare outputs
    input  wire timer_cfg_t timer_cfg_i,
    input  wire timer_out_t timer_out_i,

    // Levels delivered to the timer and interrupt controller
    output timer_in_t       timer_in_o
);

    // Bundled request and decoded functions
    reg_req_t    req;
    pin_fn_t     fn;
    port_state_t state;
    port_state_t next_state;

    // Per-pin override controls and resulting drive
    logic [7:0]  timer_oe;
    logic [7:0]  timer_val;
    logic [7:0]  drive_val;
    logic [7:0]  drive_en;
    logic [7:0]  pin_state_view;

    // Bundle the loose register-port signals
    always_comb begin
        req.addr  = reg_addr_i;
        req.wdata = reg_wdata_i;
        req.wr    = reg_wr_i;
        req.rd    = reg_rd_i;
    end

    // Address match, used by the write paths; the read path decodes with a case
    function automatic logic addr_hit(input logic [1:0] a, input logic [1:0] target);
        addr_hit = (a == target);
    endfunction : addr_hit

    // Mixed view of the port: latch where driven out, pin level where input
    function automatic logic [7:0] mixed_view(input logic [7:0] dir,
                                              input logic [7:0] latch,
                                              input logic [7:0] pins);
        mixed_view = (dir & latch) | (~dir & pins);
    endfunction : mixed_view

    // Timer function decode
    timer_pin_decode u_decode (
        .cfg_i (timer_cfg_i),
        .fn_o  (fn)
    );

    // Route timer compare outputs onto the shared pins; pins 4 to 0 stay plain
    always_comb begin
        timer_oe             = 8'h00;
        timer_val            = 8'h00;
        // channel 2 B output onto pin 7
        timer_oe[`PIN_CH2_B]  = fn.ch2_b_out;
        timer_val[`PIN_CH2_B] = timer_out_i.ch2_b;
        // channel 2 A output onto pin 6
        timer_oe[`PIN_CH2_A]  = fn.ch2_a_out;
        timer_val[`PIN_CH2_A] = timer_out_i.ch2_a;
        // channel 1 B output onto pin 5
        timer_oe[`PIN_CH1_B]  = fn.ch1_b_out;
        timer_val[`PIN_CH1_B] = timer_out_i.ch1_b;
    end

    // One selection cell per pin
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            gpio_pin_cell u_cell (
                .direction_i (state.port_direction[gi]),
                .latch_i     (state.port_output_latch[gi]),
                .timer_oe_i  (timer_oe[gi]),
                .timer_val_i (timer_val[gi]),
                .drive_val_o (drive_val[gi]),
                .drive_en_o  (drive_en[gi])
            );
        end
    endgenerate

    // readback view, latch for outputs and pin for inputs
    assign pin_state_view = mixed_view(state.port_direction, state.port_output_latch, pin_i);

    // Next-state logic for the whole port
    always_comb begin
        next_state = state;

        // direction bits take any write to their address
        if (req.wr && addr_hit(req.addr, `PORT_ADDR_DIRECTION)) begin
            next_state.port_direction = req.wdata;
        end

        if (req.wr && addr_hit(req.addr, `PORT_ADDR_LATCH)) begin
            next_state.port_output_latch = req.wdata;
        end

        // writes to the pin-state address are dropped on purpose

        // Read data stands only in the cycle after the strobe
        next_state.rd_data = 8'h00;
        if (req.rd) begin
            case (req.addr)
                // latch reads back what was written
                `PORT_ADDR_LATCH: begin
                    next_state.rd_data = state.port_output_latch;
                end
                // pin-state view, built live from latch and pins
                `PORT_ADDR_PIN_STATE: begin
                    next_state.rd_data = pin_state_view;
                end
                // Direction is write-only, so it reads as zero
                `PORT_ADDR_DIRECTION: begin
                    next_state.rd_data = `PORT_UNMAPPED_READ;
                end
                default: begin
                    next_state.rd_data = `PORT_UNMAPPED_READ;
                end
            endcase
        end

        // Pin drive is registered so the pad sees no decode glitches
        next_state.pin_out = drive_val;
        next_state.pin_oe  = drive_en;

        // timer feeds tap pin levels beside the general-purpose input path
        // pin 7 into channel 2 B capture
        next_state.feed.ch2_b_cap       = fn.ch2_b_cap & pin_i[`PIN_CH2_B];
        // pin 6 into channel 2 A capture
        next_state.feed.ch2_a_cap       = fn.ch2_a_cap & pin_i[`PIN_CH2_A];
        // pin 5 into channel 1 B capture
        next_state.feed.ch1_b_cap       = fn.ch1_b_cap & pin_i[`PIN_CH1_B];
        // pin 7 as external clock D
        next_state.feed.ext_clock_d     = fn.clock_d & pin_i[`PIN_CH2_B];
        // pin 5 as external clock C
        next_state.feed.ext_clock_c     = fn.clock_c & pin_i[`PIN_CH1_B];
        // interrupt 1 always sees pin 6; exclusivity is left to software
        next_state.feed.ext_interrupt_1 = pin_i[`PIN_CH2_A];
    end

    // State register; reset acts even with the clock enable low, which otherwise freezes everything
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            // latch and direction clear at reset
            state.port_direction    <= `PORT_DIRECTION_RST;
            state.port_output_latch <= `PORT_LATCH_RST;
            state.pin_out           <= 8'h00;
            state.pin_oe            <= 8'h00;
            state.rd_data           <= 8'h00;
            state.feed              <= '0;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // Outputs all come from the state register
    assign reg_rdata_o = state.rd_data;
    assign pin_o       = state.pin_out;
    assign pin_oe_o    = state.pin_oe;
    assign timer_in_o  = state.feed;

endmodule : port_one_gpio_pin_mux
`default_nettype wire

// [port_one_regs.svh]
// Register offsets, field positions, reset values and the functional notes of port one
//
// Functional notes
// - Eight-bit read/write output latch, cleared at reset, drives general-purpose output pins.
// - Read-only eight-bit pin-state register; writes ignored; value built live from latch and pins.
// - Pin-state read returns the output latch bit where the direction bit is 1.
// - Pin-state read returns the sampled pin level where the direction bit is 0.
// - Pin 7 carries channel 2 B output when enabled, else direction selects in/out.
// - Pin 7 feeds channel 2 B capture in normal/phase mode with B bit3 set.
// - Pin 7 is clock D when prescaler 0 or 5 is 111, or ch2/4 phase.
// - Pin 6 carries channel 2 A output when enabled, else direction selects in/out.
// - Pin 6 feeds channel 2 A capture in normal/phase mode with A bit3 set.
// - Pin 5 carries channel 1 B output when enabled, else direction selects in/out.
// - Pin 5 feeds channel 1 B capture in normal/phase mode with B control 10xx.
// - Pin 5 is clock C: prescaler 0/2 is 110, 4/5 is 101, or ch2/4 phase.
// - Write-only direction bits reset to 0; 1 makes output, 0 makes input.
`ifndef PORT_ONE_REGS_SVH
`define PORT_ONE_REGS_SVH

// Register addresses on the plain register port
`define PORT_ADDR_DIRECTION   2'h0
`define PORT_ADDR_LATCH       2'h1
`define PORT_ADDR_PIN_STATE   2'h2

// Reset values
`define PORT_DIRECTION_RST    8'h00
`define PORT_LATCH_RST        8'h00
`define PORT_UNMAPPED_READ    8'h00

// Pin positions of the timer-shared pins
`define PIN_CH2_B             7
`define PIN_CH2_A             6
`define PIN_CH1_B             5

// Io control field decode
`define IO_CTRL_BIT3          3
`define IO_CAPTURE_TOP        2'h2

// Prescaler select codes that pick an external clock pin
`define PSC_EXT_CLOCK_D       3'h7
`define PSC_EXT_CLOCK_C_LO    3'h6
`define PSC_EXT_CLOCK_C_HI    3'h5

`endif

// [port_one_pkg.sv]
// Types shared by the port one pin multiplexer files
`default_nettype none
package port_one_pkg;

    // Timer channel operating mode as seen by the port
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_PWM,
        MODE_PHASE_COUNT,
        MODE_OTHER
    } timer_mode_t;

    // Timer configuration delivered by the timer block
    typedef struct packed {
        timer_mode_t ch1_mode;
        timer_mode_t ch2_mode;
        timer_mode_t ch4_mode;
        logic [3:0]  ch1_io_b;
        logic [3:0]  ch2_io_a;
        logic [3:0]  ch2_io_b;
        logic [2:0]  psc_0;
        logic [2:0]  psc_2;
        logic [2:0]  psc_4;
        logic [2:0]  psc_5;
        logic        ch2_b_out_en;
        logic        ch2_a_out_en;
        logic        ch1_b_out_en;
    } timer_cfg_t;

    // Compare output levels from the timer
    typedef struct packed {
        logic ch2_b;
        logic ch2_a;
        logic ch1_b;
    } timer_out_t;

    // Levels fed from the pins into the timer and interrupt logic
    typedef struct packed {
        logic ch2_b_cap;
        logic ch2_a_cap;
        logic ch1_b_cap;
        logic ext_clock_c;
        logic ext_clock_d;
        logic ext_interrupt_1;
    } timer_in_t;

    // Decoded pin function selections
    typedef struct packed {
        logic ch2_b_out;
        logic ch2_a_out;
        logic ch1_b_out;
        logic ch2_b_cap;
        logic ch2_a_cap;
        logic ch1_b_cap;
        logic clock_c;
        logic clock_d;
    } pin_fn_t;

    // Register port request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // Whole state of the port
    typedef struct packed {
        logic [7:0] port_direction;
        logic [7:0] port_output_latch;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] rd_data;
        timer_in_t  feed;
    } port_state_t;

endpackage : port_one_pkg
`default_nettype wire

// [timer_pin_decode.sv]
// Decode of timer configuration into pin function selections
`timescale 1ns/1ps
`default_nettype none
`include "port_one_regs.svh"

module timer_pin_decode
    import port_one_pkg::*;
(
    // Timer configuration
    input  wire timer_cfg_t cfg_i,
    // Decoded selections
    output pin_fn_t         fn_o
);

    // Capture is possible in normal or phase counting operation
    function automatic logic capture_mode(input timer_mode_t m);
        capture_mode = (m == MODE_NORMAL) || (m == MODE_PHASE_COUNT);
    endfunction : capture_mode

    always_comb begin
        fn_o.ch2_b_out = cfg_i.ch2_b_out_en;
        fn_o.ch2_a_out = cfg_i.ch2_a_out_en;
        fn_o.ch1_b_out = cfg_i.ch1_b_out_en;
        // bit3 of the B control selects capture
        fn_o.ch2_b_cap = capture_mode(cfg_i.ch2_mode) && cfg_i.ch2_io_b[`IO_CTRL_BIT3];
        // bit3 of the A control selects capture
        fn_o.ch2_a_cap = capture_mode(cfg_i.ch2_mode) && cfg_i.ch2_io_a[`IO_CTRL_BIT3];
        // upper two control bits must read 10
        fn_o.ch1_b_cap = capture_mode(cfg_i.ch1_mode)
                         && (cfg_i.ch1_io_b[3:2] == `IO_CAPTURE_TOP);
        // clock D from prescaler 0 or 5, or phase counting
        fn_o.clock_d   = (cfg_i.psc_0 == `PSC_EXT_CLOCK_D) || (cfg_i.psc_5 == `PSC_EXT_CLOCK_D)
                         || (cfg_i.ch2_mode == MODE_PHASE_COUNT)
                         || (cfg_i.ch4_mode == MODE_PHASE_COUNT);
        // clock C from six distinct cases
        fn_o.clock_c   = (cfg_i.psc_0 == `PSC_EXT_CLOCK_C_LO)
                         || (cfg_i.psc_2 == `PSC_EXT_CLOCK_C_LO)
                         || (cfg_i.psc_4 == `PSC_EXT_CLOCK_C_HI)
                         || (cfg_i.psc_5 == `PSC_EXT_CLOCK_C_HI)
                         || (cfg_i.ch2_mode == MODE_PHASE_COUNT)
                         || (cfg_i.ch4_mode == MODE_PHASE_COUNT);
    end

endmodule : timer_pin_decode
`default_nettype wire

// [gpio_pin_cell.sv]
// Output selection for one port pin: timer override or general-purpose latch
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_cell (
    // Port settings
    input  wire logic direction_i,
    input  wire logic latch_i,
    // Timer output
    input  wire logic timer_oe_i,
    input  wire logic timer_val_i,
    // Pin drive
    output logic      drive_val_o,
    output logic      drive_en_o
);

    // Timer override beats the direction bit; an input pin drives nothing
    always_comb begin
        if (timer_oe_i) begin
            drive_val_o = timer_val_i;
            drive_en_o  = 1'b1;
        end else begin
            drive_val_o = direction_i ? latch_i : 1'b0;
            drive_en_o  = direction_i;
        end
    end

endmodule : gpio_pin_cell
`default_nettype wire

// [port_one_gpio_pin_mux_monitor.sv]
// Port-level checks for the port one pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module port_one_gpio_pin_mux_monitor
    import port_one_pkg::*;
(
    // Clock, reset, enable and register port
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic       ce_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Pins and timer
    input wire logic [7:0] pin_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_o,
    input wire timer_cfg_t timer_cfg_i,
    input wire timer_out_t timer_out_i,
    input wire timer_in_t  timer_in_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Clock D and clock C selection, several sources each
    sequence s_clk_d;
        ce_i && (timer_cfg_i.psc_0 == 3'h7 || timer_cfg_i.psc_5 == 3'h7
            || timer_cfg_i.ch2_mode == MODE_PHASE_COUNT
            || timer_cfg_i.ch4_mode == MODE_PHASE_COUNT);
    endsequence
    sequence s_clk_c;
        ce_i && (timer_cfg_i.psc_0 == 3'h6 || timer_cfg_i.psc_2 == 3'h6
            || timer_cfg_i.psc_4 == 3'h5 || timer_cfg_i.psc_5 == 3'h5
            || timer_cfg_i.ch2_mode == MODE_PHASE_COUNT
            || timer_cfg_i.ch4_mode == MODE_PHASE_COUNT);
    endsequence

    property p_oe7;
        ce_i && timer_cfg_i.ch2_b_out_en |=> pin_oe_o[7] && pin_o[7] == $past(timer_out_i.ch2_b);
    endproperty
    a_oe7: assert property (p_oe7)
        else $error("pin 7 not carrying channel 2 B output");
    property p_oe6;
        ce_i && timer_cfg_i.ch2_a_out_en |=> pin_oe_o[6] && pin_o[6] == $past(timer_out_i.ch2_a);
    endproperty
    a_oe6: assert property (p_oe6)
        else $error("pin 6 not carrying channel 2 A output");
    property p_oe5;
        ce_i && timer_cfg_i.ch1_b_out_en |=> pin_oe_o[5] && pin_o[5] == $past(timer_out_i.ch1_b);
    endproperty
    a_oe5: assert property (p_oe5)
        else $error("pin 5 not carrying channel 1 B output");
    property p_cap7;
        ce_i && timer_cfg_i.ch2_io_b[3] && timer_cfg_i.ch2_mode inside {MODE_NORMAL,
            MODE_PHASE_COUNT} |=> timer_in_o.ch2_b_cap == $past(pin_i[7]);
    endproperty
    a_cap7: assert property (p_cap7)
        else $error("channel 2 B capture not following pin 7");
    property p_cap6;
        ce_i && timer_cfg_i.ch2_io_a[3] && timer_cfg_i.ch2_mode inside {MODE_NORMAL,
            MODE_PHASE_COUNT} |=> timer_in_o.ch2_a_cap == $past(pin_i[6]);
    endproperty
    a_cap6: assert property (p_cap6)
        else $error("channel 2 A capture not following pin 6");
    property p_cap5;
        ce_i && timer_cfg_i.ch1_io_b[3:2] == 2'h2 && timer_cfg_i.ch1_mode inside {MODE_NORMAL,
            MODE_PHASE_COUNT} |=> timer_in_o.ch1_b_cap == $past(pin_i[5]);
    endproperty
    a_cap5: assert property (p_cap5)
        else $error("channel 1 B capture not following pin 5");
    property p_clkd;
        s_clk_d |=> timer_in_o.ext_clock_d == $past(pin_i[7]);
    endproperty
    a_clkd: assert property (p_clkd)
        else $error("clock D not following pin 7");
    property p_clkc;
        s_clk_c |=> timer_in_o.ext_clock_c == $past(pin_i[5]);
    endproperty
    a_clkc: assert property (p_clkc)
        else $error("clock C not following pin 5");
    // Undriven pins show no stale value
    property p_undriven;
        (pin_o & ~pin_oe_o) == 8'h00;
    endproperty
    a_undriven: assert property (p_undriven)
        else $error("value on a pin that is not driven");
    // Reset must release every pin, so no disable here
    property p_reset;
        disable iff (1'b0) rst_i |=> pin_oe_o == 8'h00 && reg_rdata_o == 8'h00;
    endproperty
    a_reset: assert property (p_reset)
        else $error("pins driven after reset");
endmodule : port_one_gpio_pin_mux_monitor

bind port_one_gpio_pin_mux port_one_gpio_pin_mux_monitor port_one_gpio_pin_mux_monitor_inst (
    .sys_clk_i, .rst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .pin_i, .pin_o, .pin_oe_o, .timer_cfg_i, .timer_out_i, .timer_in_o);
`default_nettype wire

// [port_pin_world.sv]
// Board side of port one: resolves device drive against external levels
`timescale 1ns/1ps
`default_nettype none

module port_pin_world (
    // Device drive
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe_o,
    // Level the board puts on pins the device leaves alone
    input  wire logic [7:0] ext_lvl_i,
    // Resolved levels
    output logic      [7:0] pin_i
);
    assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_lvl_i);
endmodule : port_pin_world
`default_nettype wire

// [port_one_gpio_pin_mux_tb.sv]
// Self-checking bench for the port one pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module port_one_gpio_pin_mux_tb
    import port_one_pkg::*;
;
    logic       sys_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       ce_i = 1'b1;
    logic [1:0] reg_addr_i = 2'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [7:0] ext_lvl = 8'h3c;
    timer_cfg_t timer_cfg_i = '0;
    timer_out_t timer_out_i = '0;
    logic [7:0] reg_rdata_o, pin_i, pin_o, pin_oe_o;
    timer_in_t  timer_in_o;
    int         n_mismatch = 0;
    int         compares = 0;
    int         cycles = 0;

    port_one_gpio_pin_mux port_one_gpio_pin_mux_inst (.sys_clk_i, .rst_i, .ce_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pin_i,
        .pin_o, .pin_oe_o, .timer_cfg_i, .timer_out_i, .timer_in_o);
    port_pin_world port_pin_world_inst (.pin_o, .pin_oe_o, .ext_lvl_i(ext_lvl), .pin_i);

    initial forever #10 sys_clk_i = ~sys_clk_i;

    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // Whole run is under a hundred cycles; far more means a hang
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        cmp("read data", exp, reg_rdata_o);
    endtask : rd

    task automatic pins(input logic [7:0] oe, input logic [7:0] val);
        repeat (2) @(posedge sys_clk_i);
        #1;
        cmp("pin enable", oe, pin_oe_o);
        cmp("pin value", val, pin_o);
    endtask : pins

    // Prescaler argument packs fields 0, 2, 4, 5 from the top down
    task automatic feed(input timer_mode_t m1, m2, m4, input logic [3:0] b1, a2, b2,
                        input logic [11:0] psc, input logic [7:0] lvl, input logic [5:0] exp);
        @(posedge sys_clk_i);
        timer_cfg_i <= {m1, m2, m4, b1, a2, b2, psc, 3'h0};
        ext_lvl     <= lvl;
        repeat (2) @(posedge sys_clk_i);
        #1;
        cmp("timer feed", {2'h0, exp}, {2'h0, timer_in_o});
    endtask : feed

    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h3c);
        pins(8'h00, 8'h00);
        wr(2'h0, 8'hf0);
        wr(2'h1, 8'ha5);
        rd(2'h1, 8'ha5);
        pins(8'hf0, 8'ha0);
        rd(2'h2, 8'hac);
        wr(2'h2, 8'hff);
        rd(2'h2, 8'hac);
        rd(2'h1, 8'ha5);
        rd(2'h0, 8'h00);
        rd(2'h3, 8'h00);
        // Frozen clock enable must drop the write
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        wr(2'h1, 8'h11);
        ce_i <= 1'b1;
        rd(2'h1, 8'ha5);
        // Timer outputs override input direction
        wr(2'h0, 8'h00);
        @(posedge sys_clk_i);
        timer_out_i <= 3'h2;
        timer_cfg_i <= 33'h7;
        pins(8'he0, 8'h40);
        rd(2'h2, 8'h5c);
        // Flip every compare level so a drive stuck at one value shows up
        @(posedge sys_clk_i);
        timer_out_i <= 3'h5;
        pins(8'he0, 8'ha0);
        feed(MODE_PHASE_COUNT, MODE_NORMAL, MODE_NORMAL, 4'h8, 4'h8, 4'h8,
             12'h000, 8'hff, 6'h39);
        feed(MODE_PHASE_COUNT, MODE_NORMAL, MODE_NORMAL, 4'h8, 4'h8, 4'h8,
             12'h000, 8'h00, 6'h00);
        feed(MODE_NORMAL, MODE_PWM, MODE_NORMAL, 4'hb, 4'h8, 4'h8,
             12'hf80, 8'hff, 6'h0f);
        feed(MODE_OTHER, MODE_PHASE_COUNT, MODE_NORMAL, 4'h8, 4'h8, 4'h7,
             12'h000, 8'hff, 6'h17);
        feed(MODE_NORMAL, MODE_NORMAL, MODE_PHASE_COUNT, 4'h4, 4'h0, 4'h0,
             12'h000, 8'hff, 6'h07);
        feed(MODE_NORMAL, MODE_NORMAL, MODE_NORMAL, 4'h0, 4'h0, 4'h0,
             12'h028, 8'hff, 6'h05);
        feed(MODE_NORMAL, MODE_NORMAL, MODE_NORMAL, 4'h0, 4'h0, 4'h0,
             12'h007, 8'hff, 6'h03);
        feed(MODE_NORMAL, MODE_NORMAL, MODE_NORMAL, 4'h0, 4'h0, 4'h0,
             12'hc00, 8'h20, 6'h04);
        feed(MODE_NORMAL, MODE_NORMAL, MODE_NORMAL, 4'h0, 4'h0, 4'h0,
             12'he00, 8'h80, 6'h02);
        feed(MODE_NORMAL, MODE_NORMAL, MODE_NORMAL, 4'h0, 4'h0, 4'h0,
             12'h005, 8'h20, 6'h04);
        conclude();
    end
endmodule : port_one_gpio_pin_mux_tb
`default_nettype wire
